// ---- isoe_defines.vh ----
// Constants for the increment-skip / or-literal execute block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef ISOE_DEFINES_VH
`define ISOE_DEFINES_VH
// ----------------------------------------
// Instruction word layout
// ----------------------------------------
`define ISOE_OPC_HI 13
`define ISOE_OPC_LO 8
`define ISOE_OPC_INC_SKIP 6'h0f
`define ISOE_OPC_OR_LIT 6'h38
`define ISOE_DEST_BIT 7
`define ISOE_ADDR_HI 6
`define ISOE_LIT_HI 7
// ----------------------------------------
// Phase codes and reset values
// ----------------------------------------
`define ISOE_PH_ONE 2'h0
`define ISOE_PH_TWO 2'h1
`define ISOE_PH_THREE 2'h2
`define ISOE_PH_FOUR 2'h3
`define ISOE_ACC_RESET 8'h00
`define ISOE_NOP_WORD 14'h0000
`endif

// ---- isoe_phase_gen.v ----
// Four-phase sequencer for the instruction cycle.
// Assumes one clock; each rising clk edge advances one phase.
`timescale 1ns/10ps
`include "isoe_defines.vh"
module isoe_phase_gen (
    clk,
    reset_n,
    phase_q
);
    input wire clk;
    input wire reset_n;
    output reg [1:0] phase_q;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= `ISOE_PH_ONE;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
endmodule // isoe_phase_gen

// ---- isoe_exec.v ----
// Execute stage for increment-skip-on-zero and or-literal-into-accumulator.
// Assumes the fetch path holds instr_word stable for a whole instruction
// cycle and the register file answers reg_rd_data combinationally.
// Summary of operation
// - Top bits 001111 decode as increment-skip with dest bit and address.
// - The increment goes to acc when dest is 0, else to register, no flags.
// - A zero increment turns the next cycle into an idle, discarded one.
// - A nonzero increment lets the next word run, one cycle in total.
// - Increment-skip decodes, reads, adds and writes in phases one to four.
// - Top bits 111000 decode as or-literal with an 8-bit literal.
// - Or-literal ORs the accumulator with the literal field.
// - Or-literal writes acc and updates the zero flag within one cycle.
// - Or-literal decodes, reads literal, ORs, writes in phases one to four.
`timescale 1ns/10ps
`include "isoe_defines.vh"
module isoe_exec (
    clk,
    reset_n,
    instr_word,
    reg_rd_data,
    phase_four,
    phase_one,
    reg_addr,
    reg_rd_en,
    reg_wr_en,
    reg_wr_data,
    acc,
    zero_flag,
    zero_flag_wr,
    skip_active
);
    input wire clk;
    input wire reset_n;
    input wire [13:0] instr_word;
    input wire [7:0] reg_rd_data;
    output reg phase_four;
    output reg phase_one;
    output reg [6:0] reg_addr;
    output reg reg_rd_en;
    output reg reg_wr_en;
    output reg [7:0] reg_wr_data;
    output reg [7:0] acc;
    output reg zero_flag;
    output reg zero_flag_wr;
    output reg skip_active;

    wire [1:0] phase;
    reg [13:0] ir_q;
    reg [7:0] operand_q;
    reg [7:0] result_q;
    reg is_inc_q;
    reg is_or_q;
    reg skip_q;
    wire [5:0] opc;
    wire at_phase_one;
    wire at_phase_two;
    wire at_phase_three;
    wire at_phase_four;
    wire word_is_inc;
    wire word_is_or;
    wire result_zero;
    reg [13:0] ir_d;
    reg [7:0] operand_d;
    reg [7:0] result_d;
    reg is_inc_d;
    reg is_or_d;
    reg skip_d;
    reg skip_active_d;
    reg [7:0] acc_d;
    reg zero_flag_d;
    reg zero_flag_wr_d;
    reg [6:0] reg_addr_d;
    reg reg_rd_en_d;
    reg reg_wr_en_d;
    reg [7:0] reg_wr_data_d;
    reg phase_one_d;
    reg phase_four_d;

    // ----------------------------------------
    // Phase sequencing
    // ----------------------------------------
    isoe_phase_gen u_phase (
        .clk(clk),
        .reset_n(reset_n),
        .phase_q(phase)
    );

    assign opc = instr_word[`ISOE_OPC_HI:`ISOE_OPC_LO];
    assign at_phase_one = (phase == `ISOE_PH_ONE);
    assign at_phase_two = (phase == `ISOE_PH_TWO);
    assign at_phase_three = (phase == `ISOE_PH_THREE);
    assign at_phase_four = (phase == `ISOE_PH_FOUR);
    // A word seen while skip_q is set is the discarded one
    assign word_is_inc = !skip_q && (opc == `ISOE_OPC_INC_SKIP);
    assign word_is_or = !skip_q && (opc == `ISOE_OPC_OR_LIT);
    assign result_zero = (result_q == 8'h00);

    // ----------------------------------------
    // Phase marks
    // ----------------------------------------
    always @* begin
        phase_one_d = at_phase_four;
        phase_four_d = at_phase_three;
    end

    // ----------------------------------------
    // Decode in phase one
    // ----------------------------------------
    // Only this edge samples the word; the rest of the cycle runs on ir_q
    always @* begin
        ir_d = ir_q;
        is_inc_d = is_inc_q;
        is_or_d = is_or_q;
        reg_addr_d = reg_addr;
        reg_rd_en_d = 1'b0;
        skip_active_d = skip_active;
        if (at_phase_one) begin
            ir_d = instr_word;
            is_inc_d = word_is_inc;
            is_or_d = word_is_or;
            reg_addr_d = instr_word[`ISOE_ADDR_HI:0];
            reg_rd_en_d = word_is_inc;
            skip_active_d = skip_q;
        end
    end

    // ----------------------------------------
    // Skip request
    // ----------------------------------------
    // Cleared at the next decode, so exactly one whole cycle idles
    always @* begin
        skip_d = skip_q;
        if (at_phase_one) begin
            skip_d = 1'b0;
        end else if (at_phase_four && is_inc_q) begin
            skip_d = result_zero;
        end
    end

    // ----------------------------------------
    // Operand fetch and arithmetic
    // ----------------------------------------
    // Read data is taken in phase two, while reg_rd_en is high, as the file answers combinationally
    always @* begin
        operand_d = operand_q;
        result_d = result_q;
        if (at_phase_two) begin
            if (is_inc_q) begin
                operand_d = reg_rd_data;
            end else begin
                operand_d = ir_q[`ISOE_LIT_HI:0];
            end
        end
        if (at_phase_three) begin
            if (is_inc_q) begin
                result_d = operand_q + 8'h01;
            end else begin
                result_d = acc | operand_q;
            end
        end
    end

    // ----------------------------------------
    // Write-back in phase four
    // ----------------------------------------
    always @* begin
        acc_d = acc;
        zero_flag_d = zero_flag;
        zero_flag_wr_d = 1'b0;
        reg_wr_en_d = 1'b0;
        reg_wr_data_d = reg_wr_data;
        if (at_phase_four && is_inc_q) begin
            // Status untouched by increment-skip
            if (ir_q[`ISOE_DEST_BIT]) begin
                reg_wr_en_d = 1'b1;
                reg_wr_data_d = result_q;
            end else begin
                acc_d = result_q;
            end
        end else if (at_phase_four && is_or_q) begin
            acc_d = result_q;
            zero_flag_d = result_zero;
            zero_flag_wr_d = 1'b1;
        end
    end

    // ----------------------------------------
    // Internal state
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_q <= `ISOE_NOP_WORD;
            operand_q <= 8'h00;
            result_q <= 8'h00;
            is_inc_q <= 1'b0;
            is_or_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            ir_q <= ir_d;
            operand_q <= operand_d;
            result_q <= result_d;
            is_inc_q <= is_inc_d;
            is_or_q <= is_or_d;
            skip_q <= skip_d;
        end
    end

    // ----------------------------------------
    // Output flops
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            skip_active <= 1'b0;
            acc <= `ISOE_ACC_RESET;
            zero_flag <= 1'b0;
            zero_flag_wr <= 1'b0;
            reg_addr <= 7'h00;
            reg_rd_en <= 1'b0;
            reg_wr_en <= 1'b0;
            reg_wr_data <= 8'h00;
            phase_one <= 1'b0;
            phase_four <= 1'b0;
        end else begin
            skip_active <= skip_active_d;
            acc <= acc_d;
            zero_flag <= zero_flag_d;
            zero_flag_wr <= zero_flag_wr_d;
            reg_addr <= reg_addr_d;
            reg_rd_en <= reg_rd_en_d;
            reg_wr_en <= reg_wr_en_d;
            reg_wr_data <= reg_wr_data_d;
            phase_one <= phase_one_d;
            phase_four <= phase_four_d;
        end
    end
endmodule // isoe_exec

// ---- isoe_exec_assertions.sv ----
// Timing checker bound onto isoe_exec.
// Assumes one clk domain with async active-low reset.
`timescale 1ns/10ps
module isoe_exec_checker (
    input wire clk, reset_n, phase_four, phase_one, reg_rd_en,
    input wire reg_wr_en, zero_flag, zero_flag_wr, skip_active,
    input wire [7:0] acc
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    beat_gap_a: assert property (phase_four
        |=> !phase_four [*3] ##1 phase_four) else $error("beat gap");
    beat_wrap_a: assert property (phase_four
        |=> phase_one) else $error("beat wrap");
    flag_src_a: assert property ($changed(zero_flag)
        |-> zero_flag_wr) else $error("flag source");
    flag_val_a: assert property (zero_flag_wr
        |-> zero_flag == (acc == 8'h00)) else $error("flag value");
    inc_noflag_a: assert property (reg_wr_en
        |-> !zero_flag_wr) else $error("inc flag");
    read_write_a: assert property (reg_rd_en
        |-> ##2 phase_four) else $error("read to write");
    skip_hold_a: assert property ($rose(skip_active)
        |-> skip_active [*4]) else $error("skip hold");
    skip_idle_a: assert property (skip_active
        |-> !zero_flag_wr && !reg_rd_en && !reg_wr_en)
        else $error("skip idle");
    wr_phase_a: assert property (reg_wr_en
        |-> phase_one) else $error("write phase");
endmodule // isoe_exec_checker
bind isoe_exec isoe_exec_checker i_chk (.clk, .reset_n, .phase_four,
    .phase_one, .reg_rd_en, .reg_wr_en, .zero_flag, .zero_flag_wr,
    .skip_active, .acc);

// ---- isoe_reg_model.sv ----
// Register file model beside isoe_exec.
// Assumes reads are combinational and writes land on a clk edge.
`timescale 1ns/10ps
module isoe_reg_model (
    input wire logic clk, reg_rd_en, reg_wr_en,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data
);
    logic [7:0] mem [128];
    initial for (int i = 0; i < 128; i++) mem[i] = 8'hff - 8'(i);
    // Unselected reads show inverted data so a stale value never matches
    assign reg_rd_data = reg_rd_en ? mem[reg_addr] : ~mem[reg_addr];
    always @(posedge clk) if (reg_wr_en) mem[reg_addr] <= reg_wr_data;
endmodule // isoe_reg_model

// ---- isoe_exec_bench.sv ----
// Corner and random instruction stream for isoe_exec.
// Assumes isoe_reg_model as register file; inputs move at negedge.
`timescale 1ns/10ps
module isoe_exec_bench;
    logic clk = 0, reset_n = 0, skip = 0, z = 0, re, we, zf, skp;
    logic [13:0] w = 0;
    logic [7:0] acc_e = 0, r, rd, acc, wd, mem_e [128];
    logic [6:0] ra;
    logic ph1, ph4, zw;
    logic [31:0] s = 32'd53335;
    logic [13:0] c [7] = '{14'h3800, 14'h0f00, 14'h38ff, 14'h0f80,
        14'h3855, 14'h0f80, 14'h0fff};
    int mismatches = 0, check_count = 0;
    isoe_exec i_isoe_exec (.clk, .reset_n, .instr_word(w), .acc,
        .reg_rd_data(rd), .phase_four(ph4), .phase_one(ph1), .reg_addr(ra),
        .reg_rd_en(re), .reg_wr_en(we), .reg_wr_data(wd),
        .zero_flag(zf), .zero_flag_wr(zw), .skip_active(skp));
    isoe_reg_model i_isoe_reg_model (.clk, .reg_rd_en(re), .reg_wr_en(we),
        .reg_addr(ra), .reg_wr_data(wd), .reg_rd_data(rd));
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task cmp(input logic ok);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("Error %0t: word %h", $time, w);
        end
    endtask
    task step(input logic [13:0] x);
        logic o_e, we_e;
        w = x;
        o_e = 0;
        we_e = 0;
        @(negedge clk);
        cmp(re === (!skip && x[13:8] == 6'h0f));
        @(negedge clk);
        cmp(skp === skip);
        @(negedge clk);
        cmp(ph4 === 1'b1 && ph1 === 1'b0);
        @(negedge clk);
        if (skip) skip = 0;
        else if (x[13:8] == 6'h0f) begin
            r = mem_e[x[6:0]] + 8'h01;
            we_e = x[7];
            if (x[7]) mem_e[x[6:0]] = r;
            else acc_e = r;
            skip = r == 8'h00;
        end else if (x[13:8] == 6'h38) begin
            acc_e = acc_e | x[7:0];
            z = acc_e == 8'h00;
            o_e = 1;
        end
        cmp(acc === acc_e && zf === z);
        cmp(ph1 === 1'b1 && ph4 === 1'b0 && zw === o_e);
        cmp(we === we_e);
        if (we_e) cmp(wd === r);
    endtask
    task conclude;
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 128; i++) mem_e[i] = 8'hff - 8'(i);
        repeat (5) @(negedge clk);
        reset_n = 1;
        foreach (c[i]) step(c[i]);
        repeat (400) begin
            s = xs(s);
            step({s[4] ? (s[5] ? 6'h0f : 6'h38) : s[13:8], s[23:16]});
        end
        step(14'h0000);
        for (int i = 0; i < 128; i++)
            cmp(i_isoe_reg_model.mem[i] === mem_e[i]);
        conclude;
    end
endmodule // isoe_exec_bench
